// ==== verilog/plg_pkg.sv ====
// Shared constants, states and carriers for the PLL lock detector and break guard
package plg_pkg;

    // ==========================================================
    // Counter widths and defaults
    // ==========================================================
    localparam int CNT_W = 16;             // Width of divider and confirmation counters
    localparam int REF_DIV_DEF = 8;        // System clocks per reference-divider tick
    localparam int N_ACQ_DEF = 8;          // Reference ticks to confirm tracking tolerance
    localparam int N_TRK_DEF = 8;          // Reference ticks to confirm lock tolerance
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic BRK_CLR_EN_RST = 1'b0; // Break clear enable resets to guarding
    localparam logic TRK_RST = 1'b0;       // Tracking indicator resets to acquisition
    localparam logic LOCK_RST = 1'b0;      // Lock indicator resets to unlocked
    localparam logic FLAG_RST = 1'b0;      // Lock-change flag resets clear

    // ==========================================================
    // Loop phases in automatic bandwidth mode
    // ==========================================================
    typedef enum logic [1:0] {
        PLG_ACQ,
        PLG_TRACK,
        PLG_LOCKED
    } plg_phase_t;

    // ==========================================================
    // Status carrier seen by software
    // ==========================================================
    typedef struct packed {
        logic trk;                         // Tracking indicator, 1 = tracking
        logic lock;                        // Lock indicator, 1 = locked
        logic flag;                        // Lock-change flag
        logic irq;                         // Interrupt request
        logic brk_clr_en;                  // Break clear enable
    } plg_status_t;

    // ==========================================================
    // Whole state of the block
    // ==========================================================
    typedef struct packed {
        logic trk_s1;                      // Tracking-tolerance synchroniser, first stage
        logic trk_s2;                      // Tracking-tolerance synchroniser, second stage
        logic lck_s1;                      // Lock-tolerance synchroniser, first stage
        logic lck_s2;                      // Lock-tolerance synchroniser, second stage
        logic [15:0] div;                  // Reference divider
        logic tick;                        // One-cycle reference enable
        logic [15:0] cnt;                  // Confirmation counter
        plg_phase_t phase;                 // Loop phase
        plg_status_t st;                   // Software-visible status
    } plg_state_t;

endpackage

// ==== verilog/plg_lock_guard.sv ====
// PLL acquisition/lock detector with break-state flag protection
`timescale 1ns/1ps
// What this block does
// - Break clear enable 1: clears work normally
// - Cleared flag stays cleared after break
// - Break clear enable resets 0, guards flag
// - Guarded break: control accesses keep flag
// - Tracking bit set when acquisition confirmed
// - Lock bit set when lock confirmed
// - Tracking tolerance confirmed over fixed ticks
// - Lock tolerance confirmed over fixed ticks
// - Every lock change in auto mode sets flag, maybe interrupt
// - Reset clears tracking bit, acquisition mode
module plg_lock_guard #(
    parameter int REF_DIV = plg_pkg::REF_DIV_DEF,
    parameter int N_ACQ = plg_pkg::N_ACQ_DEF,
    parameter int N_TRK = plg_pkg::N_TRK_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Analog comparator levels, asynchronous
    input wire logic in_trk_tol,
    input wire logic in_lock_tol,
    // Configuration from the bandwidth and control registers
    input wire logic pll_on,
    input wire logic auto_mode,
    input wire logic manual_trk,
    input wire logic pll_irq_en,
    // Control register access strobes, one cycle each
    input wire logic pll_control_reg_rd,
    input wire logic pll_control_reg_wr,
    // Break flag register write
    input wire logic break_flag_ctrl_reg_wr,
    input wire logic break_clear_enable_wdata,
    // Debug break state level
    input wire logic break_state,
    // Status outputs
    output logic trk_ind,
    output logic lock_ind,
    output logic pll_lock_change_flag,
    output logic pll_irq,
    output logic break_clear_enable
);

    // ==========================================================
    // State registers
    // ==========================================================
    plg_pkg::plg_state_t state_reg;        // Registered state
    plg_pkg::plg_state_t state_next;       // Next state
    logic clear_ok;                        // A flag clear is allowed this cycle
    logic lock_change;                     // Lock indicator changes this cycle

    // Terminal test for a counter against a count, used for both phases
    function automatic logic cnt_done(input logic [15:0] c, input int n);
        cnt_done = (c == 16'(n - 1));
    endfunction

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb
    begin
        state_next = state_reg;
        clear_ok = 1'b0;
        lock_change = 1'b0;
        // Two-stage synchronisers; first stage feeds only the second
        state_next.trk_s1 = in_trk_tol;
        state_next.trk_s2 = state_reg.trk_s1;
        state_next.lck_s1 = in_lock_tol;
        state_next.lck_s2 = state_reg.lck_s1;
        // Reference divider makes a one-cycle enable
        state_next.tick = 1'b0;
        if (cnt_done(state_reg.div, REF_DIV))
        begin
            state_next.div = plg_pkg::CNT_ZERO;
            state_next.tick = 1'b1;
        end
        else
        begin
            state_next.div = state_reg.div + plg_pkg::CNT_ONE;
        end
        // Loop phase sequencing
        if (!pll_on || !auto_mode)
        begin
            // Manual or off: detector idles in acquisition
            state_next.phase = plg_pkg::PLG_ACQ;
            state_next.cnt = plg_pkg::CNT_ZERO;
        end
        else if (state_reg.tick)
        begin
            case (state_reg.phase)
                plg_pkg::PLG_ACQ:
                begin
                    if (!state_reg.trk_s2)
                    begin
                        state_next.cnt = plg_pkg::CNT_ZERO;
                    end
                    else if (cnt_done(state_reg.cnt, N_ACQ))
                    begin
                        state_next.cnt = plg_pkg::CNT_ZERO;
                        state_next.phase = plg_pkg::PLG_TRACK;
                    end
                    else
                    begin
                        state_next.cnt = state_reg.cnt + plg_pkg::CNT_ONE;
                    end
                end
                plg_pkg::PLG_TRACK:
                begin
                    if (!state_reg.trk_s2)
                    begin
                        // Large error again: fall back to acquisition
                        state_next.cnt = plg_pkg::CNT_ZERO;
                        state_next.phase = plg_pkg::PLG_ACQ;
                    end
                    else if (!state_reg.lck_s2)
                    begin
                        state_next.cnt = plg_pkg::CNT_ZERO;
                    end
                    else if (cnt_done(state_reg.cnt, N_TRK))
                    begin
                        state_next.cnt = plg_pkg::CNT_ZERO;
                        state_next.phase = plg_pkg::PLG_LOCKED;
                    end
                    else
                    begin
                        state_next.cnt = state_reg.cnt + plg_pkg::CNT_ONE;
                    end
                end
                plg_pkg::PLG_LOCKED:
                begin
                    // Leaving lock tolerance drops lock at once
                    state_next.cnt = plg_pkg::CNT_ZERO;
                    if (!state_reg.trk_s2)
                    begin
                        state_next.phase = plg_pkg::PLG_ACQ;
                    end
                    else if (!state_reg.lck_s2)
                    begin
                        state_next.phase = plg_pkg::PLG_TRACK;
                    end
                end
                default:
                begin
                    state_next.phase = plg_pkg::PLG_ACQ;
                    state_next.cnt = plg_pkg::CNT_ZERO;
                end
            endcase
        end
        // tracking indicator follows phase; manual shows software bit
        if (auto_mode)
        begin
            state_next.st.trk = (state_next.phase != plg_pkg::PLG_ACQ);
        end
        else
        begin
            state_next.st.trk = manual_trk;
        end
        // lock indicator set once lock confirmed, reads 0 in manual
        state_next.st.lock = auto_mode && (state_next.phase == plg_pkg::PLG_LOCKED);
        // break clear enable written only by its register
        if (break_flag_ctrl_reg_wr)
        begin
            state_next.st.brk_clr_en = break_clear_enable_wdata;
        end
        // guarded break blocks the read-to-clear of the flag
        clear_ok = pll_control_reg_rd && (!break_state || state_reg.st.brk_clr_en);
        // any lock change in auto mode sets the flag; set wins over clear
        lock_change = auto_mode && (state_next.st.lock != state_reg.st.lock);
        if (!auto_mode)
        begin
            state_next.st.flag = 1'b0;
        end
        else if (lock_change)
        begin
            state_next.st.flag = 1'b1;
        end
        else if (clear_ok)
        begin
            // clear acts normally; nothing restores it
            state_next.st.flag = 1'b0;
        end
        state_next.st.irq = state_next.st.flag && pll_irq_en && auto_mode;
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg.trk_s1 <= 1'b0;
            state_reg.trk_s2 <= 1'b0;
            state_reg.lck_s1 <= 1'b0;
            state_reg.lck_s2 <= 1'b0;
            state_reg.div <= plg_pkg::CNT_ZERO;
            state_reg.tick <= 1'b0;
            state_reg.cnt <= plg_pkg::CNT_ZERO;
            state_reg.phase <= plg_pkg::PLG_ACQ;
            state_reg.st.trk <= plg_pkg::TRK_RST;
            state_reg.st.lock <= plg_pkg::LOCK_RST;
            state_reg.st.flag <= plg_pkg::FLAG_RST;
            state_reg.st.irq <= 1'b0;
            state_reg.st.brk_clr_en <= plg_pkg::BRK_CLR_EN_RST;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flip-flops
    assign trk_ind = state_reg.st.trk;
    assign lock_ind = state_reg.st.lock;
    assign pll_lock_change_flag = state_reg.st.flag;
    assign pll_irq = state_reg.st.irq;
    assign break_clear_enable = state_reg.st.brk_clr_en;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_clear_normal: assert property (
        state_reg.st.flag && auto_mode && pll_control_reg_rd && break_state
        && state_reg.st.brk_clr_en && !lock_change |=> !state_reg.st.flag)
        else $error("flag not cleared with break clear enable set");

    chk_clear_sticks: assert property (
        !state_reg.st.flag && !lock_change |=> !state_reg.st.flag)
        else $error("flag returned without lock change");

    chk_brk_en_hold: assert property (
        !break_flag_ctrl_reg_wr |=> $stable(state_reg.st.brk_clr_en))
        else $error("break clear enable changed without write");

    chk_flag_guard: assert property (
        state_reg.st.flag && break_state && !state_reg.st.brk_clr_en && auto_mode
        && (pll_control_reg_rd || pll_control_reg_wr) |=> state_reg.st.flag)
        else $error("guarded flag cleared during break");

    chk_trk_rise: assert property (
        auto_mode && $past(auto_mode) && $rose(state_reg.st.trk) |->
        $past(state_reg.tick) && $past(state_reg.phase) == plg_pkg::PLG_ACQ)
        else $error("tracking bit rose outside acquisition end");

    chk_lock_rise: assert property (
        $rose(state_reg.st.lock) |-> $past(state_reg.lck_s2)
        && $past(state_reg.phase) == plg_pkg::PLG_TRACK)
        else $error("lock bit rose without confirmed tolerance");

    chk_acq_count: assert property (
        auto_mode && pll_on && state_reg.tick && state_reg.phase == plg_pkg::PLG_ACQ
        && state_reg.trk_s2 && !cnt_done(state_reg.cnt, N_ACQ)
        |=> state_reg.phase == plg_pkg::PLG_ACQ)
        else $error("acquisition left before count complete");

    chk_trk_count: assert property (
        state_reg.phase == plg_pkg::PLG_TRACK ##1 state_reg.phase == plg_pkg::PLG_LOCKED
        |-> $past(cnt_done(state_reg.cnt, N_TRK)))
        else $error("lock declared before count complete");

    chk_flag_set: assert property (
        lock_change |=> state_reg.st.flag && (state_reg.st.irq == $past(pll_irq_en)))
        else $error("lock change did not set flag");

    chk_cnt_restart: assert property (
        auto_mode && pll_on && state_reg.tick && state_reg.phase == plg_pkg::PLG_ACQ
        && !state_reg.trk_s2 |=> state_reg.cnt == plg_pkg::CNT_ZERO)
        else $error("acquisition counter not restarted");

endmodule // plg_lock_guard

// ==== dv/plg_tol_model.sv ====
// Behavioural model of the analog loop feeding the tolerance comparators
`timescale 1ns/1ps
module plg_tol_model #(
    parameter int SETTLE = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Commands from the bench
    input wire logic pll_on,
    input wire logic want_trk,
    input wire logic want_lock,
    // Comparator levels
    output logic in_trk_tol,
    output logic in_lock_tol
);
    int settle_cnt; // Cycles the loop has been converging
    // ==========================================================
    // Settling model
    // ==========================================================
    // Lock tolerance is narrower, so it only holds inside tracking tolerance
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            settle_cnt <= 0;
            in_trk_tol <= 1'b0;
            in_lock_tol <= 1'b0;
        end
        else if (!pll_on || !want_trk)
        begin
            // Loop off or tracking not wanted throws the error out of both windows at once
            settle_cnt <= 0;
            in_trk_tol <= 1'b0;
            in_lock_tol <= 1'b0;
        end
        else
        begin
            if (settle_cnt < SETTLE)
                settle_cnt <= settle_cnt + 1;
            in_trk_tol <= (settle_cnt >= SETTLE);
            in_lock_tol <= (settle_cnt >= SETTLE) && want_lock;
        end
    end
endmodule // plg_tol_model

// ==== dv/plg_lock_guard_test.sv ====
// Self-checking bench for the lock detector and break guard
`timescale 1ns/1ps
module plg_lock_guard_test;
    localparam int RD = 2; // Short reference divider
    localparam int NA = 2; // Short acquisition count
    localparam int NT = 2; // Short lock count
    localparam int SEL_TRK = 0; // Watch the tracking indicator
    localparam int SEL_LOCK = 1; // Watch the lock indicator
    localparam int SEL_RD = 0; // Strobe a control register read
    localparam int SEL_WR = 1; // Strobe a control register write
    localparam int SEL_BRK = 2; // Strobe a break flag register write
    logic clk = 1'b0, reset_n = 1'b0;
    logic in_trk_tol, in_lock_tol, trk_ind, lock_ind, pll_lock_change_flag, pll_irq;
    logic break_clear_enable;
    logic pll_on = 1'b0, auto_mode = 1'b0, manual_trk = 1'b0, pll_irq_en = 1'b0;
    logic pll_control_reg_rd = 1'b0, pll_control_reg_wr = 1'b0, break_flag_ctrl_reg_wr = 1'b0;
    logic break_clear_enable_wdata = 1'b0, break_state = 1'b0;
    logic want_trk = 1'b0, want_lock = 1'b0;
    int failures = 0, tests_run = 0, n;
    // ==========================================================
    // Clock, design and loop model
    // ==========================================================
    always #12.5 clk = ~clk;
    plg_lock_guard #(.REF_DIV(RD), .N_ACQ(NA), .N_TRK(NT)) DUT (.clk(clk), .reset_n(reset_n),
        .in_trk_tol(in_trk_tol), .in_lock_tol(in_lock_tol), .pll_on(pll_on),
        .auto_mode(auto_mode), .manual_trk(manual_trk), .pll_irq_en(pll_irq_en),
        .pll_control_reg_rd(pll_control_reg_rd), .pll_control_reg_wr(pll_control_reg_wr),
        .break_flag_ctrl_reg_wr(break_flag_ctrl_reg_wr),
        .break_clear_enable_wdata(break_clear_enable_wdata), .break_state(break_state),
        .trk_ind(trk_ind), .lock_ind(lock_ind), .pll_lock_change_flag(pll_lock_change_flag),
        .pll_irq(pll_irq), .break_clear_enable(break_clear_enable));
    plg_tol_model LOOP (.clk(clk), .reset_n(reset_n), .pll_on(pll_on), .want_trk(want_trk),
        .want_lock(want_lock), .in_trk_tol(in_trk_tol), .in_lock_tol(in_lock_tol));
    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Compare one status bit, sampled on the falling edge so it has settled
    task automatic chk(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask
    // Present value of the watched status output
    function automatic logic watched(input int which);
        case (which)
            SEL_TRK: watched = trk_ind;
            SEL_LOCK: watched = lock_ind;
            default: watched = pll_lock_change_flag;
        endcase
    endfunction
    // Count cycles until a status bit takes a value, bounded
    task automatic wait_for(input int which, input logic v, output int cyc);
        cyc = 0;
        while (watched(which) !== v)
        begin
            @(negedge clk);
            cyc++;
            if (cyc > 300)
            begin
                failures++;
                $display("mismatch wait bound expected %b seen %b", v, watched(which));
                final_report();
            end
        end
    endtask
    // One-cycle strobe on a control access input; all strobes drop together
    task automatic pulse(input int which);
        @(posedge clk);
        case (which)
            SEL_RD: pll_control_reg_rd <= 1'b1;
            SEL_WR: pll_control_reg_wr <= 1'b1;
            default: break_flag_ctrl_reg_wr <= 1'b1;
        endcase
        @(posedge clk);
        pll_control_reg_rd <= 1'b0;
        pll_control_reg_wr <= 1'b0;
        break_flag_ctrl_reg_wr <= 1'b0;
        @(negedge clk);
    endtask
    // Load break clear enable through its register write
    task automatic set_brk_clr_en(input logic v);
        @(posedge clk);
        break_clear_enable_wdata <= v;
        pulse(SEL_BRK);
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset();
        @(negedge clk);
        chk("trk_ind", 1'b0, trk_ind);
        chk("break_clear_enable", 1'b0, break_clear_enable);
        chk("flag", 1'b0, pll_lock_change_flag);
        $display("test reset done");
    endtask
    // Acquire then lock; both times are whole reference intervals or longer
    task automatic t_acquire();
        @(posedge clk);
        auto_mode <= 1'b1;
        pll_on <= 1'b1;
        pll_irq_en <= 1'b1;
        want_trk <= 1'b1;
        want_lock <= 1'b1;
        wait_for(SEL_TRK, 1'b1, n);
        chk("acq long enough", 1'b1, n >= NA * RD);
        chk("lock before trk", 1'b0, lock_ind);
        wait_for(SEL_LOCK, 1'b1, n);
        chk("lock long enough", 1'b1, n >= NT * RD);
        chk("flag on lock", 1'b1, pll_lock_change_flag);
        chk("irq on lock", 1'b1, pll_irq);
        $display("test acquire done");
    endtask
    // Guarded break: neither read nor write disturbs the flag
    task automatic t_guard();
        @(posedge clk);
        break_state <= 1'b1;
        pulse(SEL_RD);
        pulse(SEL_WR);
        chk("guarded flag", 1'b1, pll_lock_change_flag);
        @(posedge clk);
        break_state <= 1'b0;
        pulse(SEL_WR);
        chk("write keeps flag", 1'b1, pll_lock_change_flag);
        $display("test guard done");
    endtask
    // Break clear enable set: clears inside break stick after exit
    task automatic t_clear();
        set_brk_clr_en(1'b1);
        chk("break_clear_enable set", 1'b1, break_clear_enable);
        @(posedge clk);
        break_state <= 1'b1;
        pulse(SEL_RD);
        chk("break clear", 1'b0, pll_lock_change_flag);
        chk("irq cleared", 1'b0, pll_irq);
        @(posedge clk);
        break_state <= 1'b0;
        repeat (4) @(negedge clk);
        chk("stays clear", 1'b0, pll_lock_change_flag);
        set_brk_clr_en(1'b0);
        chk("break_clear_enable back", 1'b0, break_clear_enable);
        $display("test clear done");
    endtask
    // Losing lock flags again; relock count starts over from zero
    task automatic t_unlock();
        @(posedge clk);
        want_lock <= 1'b0;
        wait_for(SEL_LOCK, 1'b0, n);
        chk("flag on unlock", 1'b1, pll_lock_change_flag);
        chk("still tracking", 1'b1, trk_ind);
        @(posedge clk);
        want_lock <= 1'b1;
        wait_for(SEL_LOCK, 1'b1, n);
        chk("relock restarts", 1'b1, n >= NT * RD);
        @(posedge clk);
        want_trk <= 1'b0;
        wait_for(SEL_TRK, 1'b0, n);
        chk("back to acq lock", 1'b0, lock_ind);
        @(posedge clk);
        want_trk <= 1'b1;
        wait_for(SEL_TRK, 1'b1, n);
        chk("reacq restarts", 1'b1, n >= NA * RD);
        $display("test unlock done");
    endtask
    // Manual mode: software owns the tracking bit, flag reads zero
    task automatic t_manual();
        @(posedge clk);
        auto_mode <= 1'b0;
        manual_trk <= 1'b1;
        repeat (NT * RD * 8) @(negedge clk);
        chk("manual trk", 1'b1, trk_ind);
        chk("manual lock", 1'b0, lock_ind);
        chk("manual flag", 1'b0, pll_lock_change_flag);
        chk("manual irq", 1'b0, pll_irq);
        $display("test manual done");
    endtask
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_acquire();
        t_guard();
        t_clear();
        t_unlock();
        t_manual();
        final_report();
    end
endmodule // plg_lock_guard_test
